// ### csb_consts.svh
`ifndef CSB_CONSTS_SVH
`define CSB_CONSTS_SVH

// =====================================================
// Widths and fixed values
`define CSB_XLEN        32
`define CSB_SIGN_BIT    31
`define CSB_PC_AHEAD    32'h0000_0004
`define CSB_NEXT_INSN   32'h0000_0002
`define CSB_SHIFT_FULL  6'h20
`define CSB_ALL_ONES    32'hFFFF_FFFF
`define CSB_ZERO        32'h0000_0000
`define CSB_CALL_SHIFT  12
`define CSB_RST_PC      32'h0000_0000
`define CSB_RST_FLAGS   4'h0
`define CSB_RST_TSTATE  1'h1

// =====================================================
// Opcode encoding on op_code input
`define CSB_OP_NONE     4'h0
`define CSB_OP_ASR_IMM  4'h1
`define CSB_OP_ASR_REG  4'h2
`define CSB_OP_BCOND    4'h3
`define CSB_OP_BUNC     4'h4
`define CSB_OP_BICLR    4'h5
`define CSB_OP_CALL     4'h6
`define CSB_OP_BXCH     4'h7
`define CSB_OP_CMN      4'h8
`define CSB_OP_CMPI     4'h9
`define CSB_OP_CMPR     4'hA

`endif

// ### csb_pkg.sv
package csb_pkg;
  typedef logic [31:0] csb_word_t;
  typedef struct packed {
    logic n;
    logic z;
    logic c;
    logic v;
  } csb_flags_t;
  typedef enum logic [3:0] {
    CSB_NONE, CSB_ASR_IMM, CSB_ASR_REG, CSB_BCOND, CSB_BUNC, CSB_BICLR,
    CSB_CALL, CSB_BXCH, CSB_CMN, CSB_CMPI, CSB_CMPR
  } csb_op_t;
endpackage

// ### csb_alu_if.sv
`timescale 1ns/1ps
`default_nettype none
interface csb_alu_if;
  import csb_pkg::*;
  csb_word_t a;
  csb_word_t b;
  logic      sub;
  csb_word_t res;
  logic      c;
  logic      v;
  modport core (output a, output b, output sub, input res, input c, input v);
  modport unit (input a, input b, input sub, output res, output c, output v);
endinterface
`default_nettype wire

// ### csb_addsub.sv
`timescale 1ns/1ps
`default_nettype none
module csb_addsub
  import csb_pkg::*;
(
  csb_alu_if.unit p
);
  logic [32:0] sum;
  csb_word_t   bb;
  always_comb begin
    bb  = p.sub ? ~p.b : p.b;
    sum = {1'b0, p.a} + {1'b0, bb} + {32'h0, p.sub};
  end
  assign p.res = sum[31:0];
  assign p.c   = sum[32];
  assign p.v   = (p.a[31] == bb[31]) && (sum[31] != p.a[31]);
endmodule
`default_nettype wire

// ### csb_asr.sv
`timescale 1ns/1ps
`default_nettype none
`include "csb_consts.svh"
module csb_asr
  import csb_pkg::*;
(
  // Operand and amount
  input  wire csb_word_t   val,
  input  wire logic [7:0]  amt,
  // Result
  output csb_word_t        res,
  output logic             cout
);
  always_comb begin
    if (amt >= 8'h20) begin
      res  = {32{val[`CSB_SIGN_BIT]}};
      cout = val[`CSB_SIGN_BIT];
    end else if (amt == 8'h00) begin
      res  = val;
      cout = 1'b0;
    end else begin
      res  = csb_word_t'($signed(val) >>> amt[4:0]);
      cout = val[amt[4:0] - 5'h01];
    end
  end
endmodule
`default_nettype wire

// ### csb_exec.sv
`timescale 1ns/1ps
`default_nettype none
`include "csb_consts.svh"
// Summary of operation
// - Immediate shift field zero means thirty-two
// - Shift thirty-two gives sign fill, carry sign
// - Immediate shift sign-extends, sets N Z
// - Register amount zero keeps dest and carry
// - Amount 1..31: carry bit amount-1, shift
// - Amount 32+: carry sign, sign fill
// - Vacated bits take sign, flags updated
// - Conditional branch: offset8 times two plus PC
// - Branch only when condition passes
// - Unconditional branch: offset11 times two plus PC
// - Address wraparound results undefined
// - Bit clear: dest AND NOT second operand
// - Call first half: link gets PC plus offset<<12
// - Call second half: PC from link, return link
// - Exchange: state bit from bit zero
// - High select chooses high or low register
// - To wide set, clear two low bits
// - Compare negative sets flags from sum
// - Compare immediate sets flags from difference
// - Register compare sets flags from difference
module csb_exec
  import csb_pkg::*;
(
  // Clock and reset
  input  wire logic        clk,
  input  wire logic        sys_rst,
  // Issued instruction
  input  wire logic        issue,
  input  wire logic [3:0]  op_code,
  input  wire logic [10:0] imm_field,
  input  wire logic        cond_pass,
  input  wire logic        high_reg_select_second,
  input  wire logic        call_half_select,
  input  wire csb_word_t   insn_addr,
  // Register operands
  input  wire csb_word_t   dest_reg,
  input  wire csb_word_t   first_operand_reg,
  input  wire csb_word_t   second_operand_reg,
  input  wire csb_word_t   second_operand_high,
  input  wire csb_word_t   shift_amount_reg,
  input  wire logic        shifter_carry,
  // Architectural state
  output csb_word_t        pc,
  output csb_word_t        link_register,
  output logic             instr_set_state_flag,
  output csb_flags_t       flags,
  // Destination write-back
  output logic             dest_we,
  output csb_word_t        dest_wdata
);
  csb_word_t   pc_ahead;
  csb_word_t   op_m;
  csb_word_t   shift_in;
  logic [7:0]  shift_amt;
  csb_word_t   shift_res;
  logic        shift_c;
  csb_word_t   bic_res;
  csb_word_t   off8;
  csb_word_t   off11;
  csb_word_t   off_lo;
  csb_word_t   call_hi;
  csb_word_t   next_pc;
  csb_flags_t  next_flags;
  logic        is_cmp;
  csb_alu_if   alu ();

  // =====================================================
  // Operand selection
  assign pc_ahead = insn_addr + `CSB_PC_AHEAD;
  assign op_m = high_reg_select_second ? second_operand_high
                                       : second_operand_reg;
  assign off8 = {{23{imm_field[7]}}, imm_field[7:0], 1'b0};
  assign off11 = {{20{imm_field[10]}}, imm_field, 1'b0};
  // Second call half offset is the unsigned low part
  assign off_lo = {20'h0, imm_field, 1'b0};
  assign call_hi = {{9{imm_field[10]}}, imm_field,
                    `CSB_CALL_SHIFT'(0)};
  assign bic_res = dest_reg & ~second_operand_reg;

  always_comb begin
    shift_in = dest_reg;
    shift_amt = shift_amount_reg[7:0];
    if (op_code == `CSB_OP_ASR_IMM) begin
      shift_in = second_operand_reg;
      shift_amt = (imm_field[4:0] == 5'h00) ?
                  {2'h0, `CSB_SHIFT_FULL} : {3'h0, imm_field[4:0]};
    end
  end

  csb_asr u_asr (
    .val  (shift_in),
    .amt  (shift_amt),
    .res  (shift_res),
    .cout (shift_c)
  );

  // =====================================================
  // Adder for compares
  always_comb begin
    alu.a   = first_operand_reg;
    alu.b   = op_m;
    alu.sub = 1'b1;
    if (op_code == `CSB_OP_CMN) begin
      alu.b   = second_operand_reg;
      alu.sub = 1'b0;
    end else if (op_code == `CSB_OP_CMPI) begin
      alu.b   = {24'h0, imm_field[7:0]};
    end
  end

  csb_addsub u_add (
    .p (alu.unit)
  );

  assign is_cmp = (op_code == `CSB_OP_CMN) || (op_code == `CSB_OP_CMPI) ||
                  (op_code == `CSB_OP_CMPR);

  // =====================================================
  // Next PC; targets wrap silently, no check made
  always_comb begin
    next_pc = pc_ahead;
    case (op_code)
      `CSB_OP_BCOND: if (cond_pass) next_pc = pc_ahead + off8;
      `CSB_OP_BUNC:  next_pc = pc_ahead + off11;
      `CSB_OP_CALL:  if (call_half_select)
                       next_pc = link_register + off_lo;
      `CSB_OP_BXCH:  next_pc = op_m[0] ? {op_m[31:1], 1'b0}
                                       : {op_m[31:2], 2'b00};
      default:       next_pc = pc_ahead;
    endcase
  end

  // =====================================================
  // Next flags
  always_comb begin
    next_flags = flags;
    case (op_code)
      `CSB_OP_ASR_IMM, `CSB_OP_ASR_REG: begin
        if (shift_amt != 8'h00) begin
          next_flags.n = shift_res[`CSB_SIGN_BIT];
          next_flags.z = (shift_res == `CSB_ZERO);
          next_flags.c = shift_c;
        end
      end
      `CSB_OP_BICLR: begin
        next_flags.n = bic_res[`CSB_SIGN_BIT];
        next_flags.z = (bic_res == `CSB_ZERO);
        next_flags.c = shifter_carry;
      end
      `CSB_OP_CMN, `CSB_OP_CMPI, `CSB_OP_CMPR: begin
        next_flags.n = alu.res[`CSB_SIGN_BIT];
        next_flags.z = (alu.res == `CSB_ZERO);
        next_flags.c = alu.c;
        next_flags.v = alu.v;
      end
      default: next_flags = flags;
    endcase
  end

  // =====================================================
  // State registers
  always_ff @(posedge clk) begin
    if (sys_rst) pc <= `CSB_RST_PC;
    else if (issue) pc <= next_pc;
  end

  always_ff @(posedge clk) begin
    if (sys_rst) flags <= `CSB_RST_FLAGS;
    else if (issue) flags <= next_flags;
  end

  always_ff @(posedge clk) begin
    if (sys_rst) link_register <= `CSB_ZERO;
    else if (issue && op_code == `CSB_OP_CALL) begin
      if (!call_half_select)
        link_register <= pc_ahead + call_hi;
      else
        link_register <= (insn_addr + `CSB_NEXT_INSN) | 32'h1;
    end
  end

  always_ff @(posedge clk) begin
    if (sys_rst) instr_set_state_flag <= `CSB_RST_TSTATE;
    else if (issue && op_code == `CSB_OP_BXCH)
      instr_set_state_flag <= op_m[0];
  end

  always_ff @(posedge clk) begin
    if (sys_rst) begin
      dest_we    <= 1'b0;
      dest_wdata <= `CSB_ZERO;
    end else begin
      dest_we    <= 1'b0;
      if (issue && !is_cmp) begin
        if (op_code == `CSB_OP_ASR_IMM ||
            (op_code == `CSB_OP_ASR_REG && shift_amt != 8'h00)) begin
          dest_we    <= 1'b1;
          dest_wdata <= shift_res;
        end else if (op_code == `CSB_OP_BICLR) begin
          dest_we    <= 1'b1;
          dest_wdata <= bic_res;
        end
      end
    end
  end

  // =====================================================
  // Checks: shifts
  a_asr_zero_keep: assert property (
    @(posedge clk) disable iff (sys_rst)
    issue && op_code == `CSB_OP_ASR_REG && shift_amount_reg[7:0] == 8'h00
    |=> !dest_we && flags.c == $past(flags.c))
    else $error("zero shift changed");
  a_asr_mid_carry: assert property (
    @(posedge clk) disable iff (sys_rst)
    issue && op_code == `CSB_OP_ASR_REG && shift_amount_reg[7:0] != 8'h00 &&
    shift_amount_reg[7:0] < 8'h20
    |=> dest_we && flags.c == $past(dest_reg[shift_amount_reg[4:0] - 5'h01]))
    else $error("mid shift carry wrong");
  a_asr_big_fill: assert property (
    @(posedge clk) disable iff (sys_rst)
    issue && op_code == `CSB_OP_ASR_REG && shift_amount_reg[7:0] >= 8'h20
    |=> dest_wdata == {32{$past(dest_reg[31])}} &&
        flags.c == $past(dest_reg[31]))
    else $error("big shift wrong");
  a_asr_sign_keep: assert property (
    @(posedge clk) disable iff (sys_rst)
    issue && op_code == `CSB_OP_ASR_REG && shift_amount_reg[7:0] != 8'h00
    |=> dest_we && dest_wdata[31] == $past(dest_reg[31]) &&
        flags.n == dest_wdata[31])
    else $error("shift lost sign");
  a_imm_zero_fill: assert property (
    @(posedge clk) disable iff (sys_rst)
    issue && op_code == `CSB_OP_ASR_IMM && imm_field[4:0] == 5'h00
    |=> dest_wdata == {32{$past(second_operand_reg[31])}} &&
        flags.c == $past(second_operand_reg[31]))
    else $error("imm 32 wrong");
  a_imm_flags: assert property (
    @(posedge clk) disable iff (sys_rst)
    issue && op_code == `CSB_OP_ASR_IMM
    |=> dest_we && dest_wdata[31] == $past(second_operand_reg[31]) &&
        flags.n == dest_wdata[31] && flags.v == $past(flags.v) &&
        flags.z == (dest_wdata == `CSB_ZERO))
    else $error("imm shift flags wrong");
  // =====================================================
  // Checks: branches
  a_bcond_taken: assert property (
    @(posedge clk) disable iff (sys_rst)
    issue && op_code == `CSB_OP_BCOND && cond_pass
    |=> pc == $past(insn_addr) + `CSB_PC_AHEAD + $past(off8))
    else $error("branch target wrong");
  a_bcond_skip: assert property (
    @(posedge clk) disable iff (sys_rst)
    issue && op_code == `CSB_OP_BCOND && !cond_pass
    |=> pc == $past(insn_addr) + `CSB_PC_AHEAD)
    else $error("branch taken");
  a_bunc_target: assert property (
    @(posedge clk) disable iff (sys_rst)
    issue && op_code == `CSB_OP_BUNC
    |=> pc == $past(insn_addr) + `CSB_PC_AHEAD + $past(off11))
    else $error("bad target");
  a_call_first: assert property (
    @(posedge clk) disable iff (sys_rst)
    issue && op_code == `CSB_OP_CALL && !call_half_select
    |=> link_register == $past(pc_ahead) + $past(call_hi))
    else $error("call first half link wrong");
  a_call_target: assert property (
    @(posedge clk) disable iff (sys_rst)
    issue && op_code == `CSB_OP_CALL && call_half_select
    |=> pc == $past(link_register) + $past(off_lo))
    else $error("call target wrong");
  a_call_link: assert property (
    @(posedge clk) disable iff (sys_rst)
    issue && op_code == `CSB_OP_CALL && call_half_select
    |=> link_register == ($past(insn_addr) + `CSB_NEXT_INSN | 32'h1))
    else $error("return link wrong");
  a_bx_state: assert property (
    @(posedge clk) disable iff (sys_rst)
    issue && op_code == `CSB_OP_BXCH
    |=> instr_set_state_flag == $past(op_m[0]) && !pc[0])
    else $error("bx state");
  a_bx_select: assert property (
    @(posedge clk) disable iff (sys_rst)
    issue && op_code == `CSB_OP_BXCH && high_reg_select_second
    |=> instr_set_state_flag == $past(second_operand_high[0]))
    else $error("bx operand select wrong");
  a_bx_wide: assert property (
    @(posedge clk) disable iff (sys_rst)
    issue && op_code == `CSB_OP_BXCH && !op_m[0]
    |=> pc == {$past(op_m[31:2]), 2'b00})
    else $error("bx wide target wrong");
  // =====================================================
  // Checks: logic and compares
  a_bic_result: assert property (
    @(posedge clk) disable iff (sys_rst)
    issue && op_code == `CSB_OP_BICLR
    |=> dest_we && dest_wdata == $past(dest_reg & ~second_operand_reg) &&
        flags.c == $past(shifter_carry))
    else $error("bit clear wrong");
  a_bic_v_keep: assert property (
    @(posedge clk) disable iff (sys_rst)
    issue && op_code == `CSB_OP_BICLR
    |=> flags.v == $past(flags.v))
    else $error("bic touched v");
  a_cmn_zero: assert property (
    @(posedge clk) disable iff (sys_rst)
    issue && op_code == `CSB_OP_CMN
    |=> flags.z ==
        ($past(csb_word_t'(first_operand_reg + second_operand_reg)) == 0))
    else $error("compare negative zero wrong");
  a_cmpi_carry: assert property (
    @(posedge clk) disable iff (sys_rst)
    issue && op_code == `CSB_OP_CMPI
    |=> flags.c == $past(first_operand_reg >= {24'h0, imm_field[7:0]}))
    else $error("compare immediate carry wrong");
  a_cmpr_flags: assert property (
    @(posedge clk) disable iff (sys_rst)
    issue && op_code == `CSB_OP_CMPR
    |=> flags.z == $past(first_operand_reg == op_m) &&
        flags.c == $past(first_operand_reg >= op_m))
    else $error("register compare flags wrong");
  a_cmp_no_write: assert property (
    @(posedge clk) disable iff (sys_rst)
    issue && is_cmp
    |=> !dest_we)
    else $error("compare wrote dest");
endmodule
`default_nettype wire

// ### tb_top.sv
`timescale 1ns/1ps
`default_nettype none
module tb_top
  import csb_pkg::*;
;
  // ============================================
  // Design under test
  logic       clk;
  logic       sys_rst;
  logic       issue;
  logic [3:0] op_code;
  logic [10:0] imm_field;
  logic       cond_pass;
  logic       high_reg_select_second;
  logic       call_half_select;
  logic       shifter_carry;
  logic       instr_set_state_flag;
  logic       dest_we;
  csb_flags_t flags;
  csb_word_t  insn_addr, dest_reg, first_operand_reg, second_operand_reg;
  csb_word_t  second_operand_high, shift_amount_reg;
  csb_word_t  pc, link_register, dest_wdata;

  csb_exec csb_exec_i (.clk, .sys_rst, .issue, .op_code, .imm_field,
    .cond_pass, .high_reg_select_second, .call_half_select, .insn_addr,
    .dest_reg, .first_operand_reg, .second_operand_reg, .second_operand_high,
    .shift_amount_reg, .shifter_carry, .pc, .link_register,
    .instr_set_state_flag, .flags, .dest_we, .dest_wdata);

  // ============================================
  // Stimulus and expected state
  logic       s_iss, s_cp, s_hs, s_ch, s_sc, e_st, e_we, e_keep;
  logic [3:0] s_op, e_fl, e_mask;
  logic [10:0] s_im;
  csb_word_t  s_ia, s_dr, s_fr, s_sr, s_sh, s_sa, e_pc, e_lr, e_wd;
  int         seed = 71359;
  int         n_errors = 0;
  int         n_tests = 0;
  int         cyc = 0;

  initial clk = 1'h0;
  always #5 clk = ~clk;

  always @(posedge clk) begin
    cyc++;
    if (cyc == 20000) begin
      n_errors++;
      close_out();
    end
  end

  function automatic logic [32:0] asr_fn(csb_word_t v, int n);
    if (n >= 32) return {v[31], {32{v[31]}}};
    return {v[n-1], csb_word_t'($signed(v) >>> n)};
  endfunction

  task automatic set_nz(csb_word_t r);
    e_fl[3:2] = {r[31], r == 32'h0};
    e_mask[3:2] = 2'h3;
  endtask

  task automatic arith(csb_word_t a, csb_word_t b, logic sub);
    logic [32:0] s;
    csb_word_t bb;
    bb = sub ? ~b : b;
    s = {1'h0, a} + {1'h0, bb} + 33'(sub);
    set_nz(s[31:0]);
    e_fl[1:0] = {s[32], a[31] == bb[31] && s[31] != a[31]};
    e_mask = 4'hF;
  endtask

  // Next expected state from the instruction just driven
  task automatic model();
    logic [32:0] r;
    csb_word_t m;
    e_we = 1'h0;
    e_keep = 1'h0;
    if (!s_iss) return;
    e_pc = s_ia + 32'h4;
    m = s_hs ? s_sh : s_sr;
    case (s_op)
      4'h1: begin
        r = asr_fn(s_sr, s_im[4:0] == 5'h0 ? 32 : int'(s_im[4:0]));
        set_nz(r[31:0]);
        e_fl[1] = r[32];
        e_mask[1] = s_im[4:0] == 5'h0;
        {e_we, e_wd} = {1'h1, r[31:0]};
      end
      4'h2: if (s_sa[7:0] == 8'h0) begin
        e_mask[3:2] = 2'h0;
        {e_keep, e_wd} = {1'h1, s_dr};
      end else begin
        r = asr_fn(s_dr, int'(s_sa[7:0]));
        set_nz(r[31:0]);
        e_fl[1] = r[32];
        e_mask[0] = 1'h0;
        {e_we, e_wd} = {1'h1, r[31:0]};
      end
      4'h3: if (s_cp) e_pc += {{23{s_im[7]}}, s_im[7:0], 1'h0};
      4'h4: e_pc += {{20{s_im[10]}}, s_im, 1'h0};
      4'h5: begin
        set_nz(s_dr & ~s_sr);
        e_fl[1] = s_sc;
        e_mask[1] = 1'h1;
        {e_we, e_wd} = {1'h1, s_dr & ~s_sr};
      end
      4'h6: if (!s_ch) e_lr = e_pc + {{9{s_im[10]}}, s_im, 12'h0};
      else begin
        e_pc = e_lr + {20'h0, s_im, 1'h0};
        e_lr = (s_ia + 32'h2) | 32'h1;
      end
      4'h7: begin
        e_st = m[0];
        e_pc = m & (m[0] ? ~32'h1 : ~32'h3);
      end
      4'h8: arith(s_fr, s_sr, 1'h0);
      4'h9: arith(s_fr, {24'h0, s_im[7:0]}, 1'h1);
      4'hA: arith(s_fr, m, 1'h1);
      default: ;
    endcase
  endtask

  task automatic chk(string nm, logic [31:0] seen, logic [31:0] exp);
    n_tests++;
    if (seen !== exp) begin
      n_errors++;
      $display("BAD %s exp %h seen %h", nm, exp, seen);
    end
  endtask

  task automatic step();
    @(posedge clk);
    issue <= s_iss;
    op_code <= s_op;
    imm_field <= s_im;
    {cond_pass, high_reg_select_second} <= {s_cp, s_hs};
    {call_half_select, shifter_carry} <= {s_ch, s_sc};
    {insn_addr, dest_reg, first_operand_reg} <= {s_ia, s_dr, s_fr};
    {second_operand_reg, second_operand_high} <= {s_sr, s_sh};
    shift_amount_reg <= s_sa;
    #1;
    chk("pc", pc, e_pc);
    chk("link", link_register, e_lr);
    chk("state", 32'(instr_set_state_flag), 32'(e_st));
    chk("flags", 32'(flags & e_mask), 32'(e_fl & e_mask));
    if (!e_keep) chk("we", 32'(dest_we), 32'(e_we));
    if (e_we || (e_keep && dest_we === 1'h1))
      chk("wdata", dest_wdata, e_wd);
    model();
  endtask

  task automatic run(logic [3:0] op, logic [10:0] im, csb_word_t a,
                     csb_word_t b, logic f);
    {s_iss, s_op, s_im} = {1'h1, op, im};
    {s_cp, s_hs, s_ch, s_sc} = {f, f, f, ~f};
    {s_dr, s_fr, s_sr, s_sa} = {a, a, b, b};
    s_sh = ~b ^ 32'h5;
    s_ia = {4'h1, 27'($random(seed)), 1'h0};
    step();
  endtask

  task automatic do_rst();
    @(posedge clk);
    sys_rst <= 1'h1;
    issue <= 1'h0;
    repeat (3) @(posedge clk);
    sys_rst <= 1'h0;
    {e_pc, e_lr, e_st, e_fl, e_mask} = {64'h0, 1'h1, 4'h0, 4'hF};
    {e_we, e_keep, s_iss} = 3'h0;
  endtask

  task automatic close_out();
    $display("tests %0d errors %0d", n_tests, n_errors);
    if (n_errors == 0 && n_tests > 0) $display("Testbench passed");
    else $display("Testbench failed");
    $finish;
  endtask

  // ============================================
  // Main sequence
  initial begin
    logic [31:0] r, b;
    {sys_rst, issue, op_code, imm_field, cond_pass} = {1'h1, 17'h0};
    {high_reg_select_second, call_half_select, shifter_carry} = 3'h0;
    {insn_addr, dest_reg, first_operand_reg, second_operand_reg} = 128'h0;
    {second_operand_high, shift_amount_reg} = 64'h0;
    do_rst();
    run(4'h1, 11'h0, 32'h0, 32'h8000_0001, 1'h0);
    run(4'h1, 11'h0, 32'h0, 32'h7FFF_FFFF, 1'h0);
    run(4'h1, 11'h1F, 32'h0, 32'h8000_0000, 1'h0);
    run(4'h2, 11'h0, 32'h8000_00F0, 32'h100, 1'h0);
    run(4'h2, 11'h0, 32'hF0F0_0001, 32'h1, 1'h0);
    run(4'h2, 11'h0, 32'h8F0F_0002, 32'h1F, 1'h0);
    run(4'h2, 11'h0, 32'h8000_0000, 32'h20, 1'h0);
    run(4'h2, 11'h0, 32'h7000_0000, 32'hFF, 1'h0);
    run(4'h3, 11'h80, 32'h0, 32'h0, 1'h1);
    run(4'h3, 11'h7F, 32'h0, 32'h0, 1'h0);
    run(4'h4, 11'h400, 32'h0, 32'h0, 1'h0);
    run(4'h5, 11'h0, 32'hFFFF_0000, 32'h8000_0000, 1'h0);
    run(4'h6, 11'h7FF, 32'h0, 32'h0, 1'h0);
    run(4'h6, 11'h7FF, 32'h0, 32'h0, 1'h1);
    run(4'h7, 11'h0, 32'h0, 32'h0000_1003, 1'h0);
    run(4'h7, 11'h0, 32'h0, 32'hEDCB_A988, 1'h1);
    run(4'h8, 11'h0, 32'h7FFF_FFFF, 32'h1, 1'h0);
    run(4'h8, 11'h0, 32'hFFFF_FFFF, 32'h1, 1'h0);
    run(4'h9, 11'hFF, 32'hFF, 32'h0, 1'h0);
    run(4'h9, 11'h1, 32'h8000_0000, 32'h0, 1'h0);
    run(4'hA, 11'h0, 32'h1234, 32'h1234, 1'h0);
    run(4'hA, 11'h0, 32'h1, 32'h5, 1'h1);
    run(4'hF, 11'h0, 32'h0, 32'h0, 1'h0);
    do_rst();
    repeat (1500) begin
      r = $random(seed);
      b = $random(seed);
      if (r[5]) b[7:5] = 3'h0;
      run(r[3:0], r[26:16], $random(seed), b, r[4] & (r[3:0] != 4'h6));
      if (r[3:0] == 4'h6) run(4'h6, r[26:16], r, b, 1'h1);
      if (r[9:7] == 3'h0) begin
        s_iss = 1'h0;
        step();
      end
    end
    step();
    close_out();
  end
endmodule
`default_nettype wire
